//--- dv/mode_sense_header_descriptor_bench.sv
// bench for the mode sense header block: apb register checks, events from the tape model
// assumes one 40 MHz pclk, ce high except one freeze test, write delay unit shortened to 4 cycles
`timescale 1ns/100ps
module mode_sense_header_descriptor_bench;
   import mode_sense_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic unload_btn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, flush_req, cmd_status, er;
   tape_t tape;
   evt_t evt;
   int miscompares = 0;
   int total_checks = 0;
   int nfl = 0;
   int nst = 0;
   int p;
   row_t rows [6] = '{
      '{OFF_PAGELEN, 32'h00000005, 32'h00000005, 1'b0},
      '{OFF_WDELAY, 32'h00001234, 32'h00001234, 1'b0},
      '{OFF_BLKLEN, 32'h00000000, 32'h00000000, 1'b0},
      '{OFF_BLKLEN, 32'h0003C000, 32'h0003C000, 1'b0},
      '{8'h28, 32'hFFFFFFFF, 32'h00000000, 1'b1},
      '{OFF_BLKMAX, 32'h00000800, 32'h00000800, 1'b0}};

   always #12.5 pclk = ~pclk;

   mode_sense_header #(.WD_UNIT_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tape(tape), .evt(evt), .unload_btn(unload_btn), .flush_req(flush_req),
      .cmd_status(cmd_status));
   tape_mech_model u_tape (.pclk(pclk), .tape(tape), .evt(evt));

   always @(posedge pclk)
   begin
      if (flush_req === 1'b1)
         nfl++;
      if (cmd_status === 1'b1)
         nst++;
   end

   task results;
      begin
         $display("checks %0d miscompares %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      begin
         total_checks++;
         if (g !== x)
         begin
            $display("[ERR] %s expected %h seen %h", n, x, g);
            miscompares++;
         end
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do
         begin
            @(posedge pclk);
            n++;
         end
         while (pready !== 1'b1 && n < 16);
         if (pready !== 1'b1)
         begin
            miscompares++;
            results;
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task rdc(input string n, input logic [7:0] a, input logic [31:0] x);
      begin
         apb(1'b0, a, 32'h00000000);
         chk(n, x, rd);
      end
   endtask

   task tick(input int n);
      begin
         repeat (n) @(posedge pclk);
      end
   endtask

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc("mode", OFF_MODE, 32'h00000010);
      rdc("density", OFF_DENSITY, 32'h00000000);
      rdc("blklen", OFF_BLKLEN, 32'h00000400);
      rdc("blkmax", OFF_BLKMAX, 32'h0003C000);
      rdc("header", OFF_HEADER, 32'h0B001008);
      rdc("desc_lo", OFF_DESC_LO, 32'h00000400);
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h00000000);
         chk($sformatf("row%0d", i), rows[i].x, rd);
         chk($sformatf("row%0d err", i), rows[i].e, er);
      end
      apb(1'b1, OFF_BLKLEN, 32'h00000801);
      rdc("blklen over", OFF_BLKLEN, 32'h0003C000);
      apb(1'b0, OFF_STATUS, 32'h00000000);
      chk("blkerr", 32'h00000004, rd & 32'h00000004);
      apb(1'b1, OFF_STATUS, 32'h00000004);
      apb(1'b0, OFF_STATUS, 32'h00000000);
      chk("blkerr clr", 32'h00000000, rd & 32'h00000004);
      apb(1'b1, OFF_MODE, 32'h00000011);
      rdc("header nodesc", OFF_HEADER, 32'h08001000);
      apb(1'b1, OFF_MODE, 32'h00000010);
      rdc("header page", OFF_HEADER, 32'h10001008);
      apb(1'b1, OFF_PAGELEN, 32'h00000000);
      apb(1'b1, OFF_WDELAY, 32'h00000000);
      apb(1'b1, OFF_MODE, 32'h00000000);
      rdc("header unbuf", OFF_HEADER, 32'h0B000008);
      p = nfl;
      u_tape.pulse(2);
      tick(3);
      chk("unbuf flush", p + 1, nfl);
      p = nst;
      u_tape.pulse(1);
      tick(3);
      chk("unbuf no status", p, nst);
      u_tape.pulse(0);
      tick(3);
      chk("unbuf status", p + 1, nst);
      apb(1'b1, OFF_MODE, 32'h00000010);
      p = nst;
      u_tape.pulse(1);
      tick(3);
      chk("buf status", p + 1, nst);
      apb(1'b1, OFF_WDELAY, 32'h00000002);
      p = nfl;
      u_tape.pulse(2);
      tick(3);
      chk("delay early", p, nfl);
      tick(20);
      chk("delay flush", p + 1, nfl);
      apb(1'b1, OFF_WDELAY, 32'h00000000);
      p = nfl;
      u_tape.pulse(2);
      tick(60);
      chk("zero delay", p, nfl);
      for (int k = 12; k >= 6; k--)
      begin
         u_tape.pulse(2);
         tick(2);
         p = nfl;
         u_tape.pulse(k);
         tick(3);
         chk($sformatf("flush evt%0d", k), p + 1, nfl);
      end
      p = nfl;
      u_tape.pulse(11);
      tick(3);
      chk("empty rewind", p, nfl);
      u_tape.pulse(2);
      tick(2);
      unload_btn <= 1'b1;
      tick(8);
      unload_btn <= 1'b0;
      chk("button flush", p + 1, nfl);
      ce <= 1'b0;
      u_tape.pulse(2);
      ce <= 1'b1;
      p = nfl;
      u_tape.pulse(11);
      tick(3);
      chk("ce freeze", p, nfl);
      apb(1'b1, OFF_DENSITY, 32'h00000014);
      apb(1'b1, OFF_DENSITY, 32'h0000007F);
      apb(1'b0, OFF_DESC_HI, 32'h00000000);
      chk("dens keep", 32'h14, rd[31:24]);
      apb(1'b1, OFF_MODE, 32'h00000014);
      u_tape.load(1'b1, 1'b0, 8'h15, 3'h1, 24'h001000);
      rdc("header wp", OFF_HEADER, 32'h0BC29008);
      rdc("desc rec", OFF_DESC_HI, 32'h15002000);
      u_tape.resize(1'b0, 3'h4);
      apb(1'b0, OFF_HEADER, 32'h00000000);
      chk("resized", 32'h85, rd[23:16]);
      apb(1'b1, OFF_DENSITY, 32'h00000014);
      rdc("desc sel", OFF_DESC_HI, 32'h14002000);
      u_tape.pulse(5);
      rdc("desc read", OFF_DESC_HI, 32'h15002000);
      u_tape.pulse(4);
      rdc("desc write", OFF_DESC_HI, 32'h14002000);
      u_tape.pulse(3);
      apb(1'b1, OFF_DENSITY, 32'h00000014);
      u_tape.pulse(4);
      rdc("desc append", OFF_DESC_HI, 32'h15002000);
      u_tape.unload;
      apb(1'b1, OFF_DENSITY, 32'h00000014);
      u_tape.load(1'b0, 1'b1, 8'h00, 3'h0, 24'h000800);
      rdc("blank hdr", OFF_HEADER, 32'h0BC11008);
      rdc("blank desc", OFF_DESC_HI, 32'h15001000);
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      rdc("mode rst", OFF_MODE, 32'h00000010);
      rdc("blklen rst", OFF_BLKLEN, 32'h00000400);
      results;
   end
endmodule // mode_sense_header_descriptor_bench

//--- dv/tape_mech_model.sv
// tape mechanism model: cartridge status levels and one-cycle motion and command events
// assumes the bench calls its tasks from pclk-synchronous code; outputs change after rising edges
`timescale 1ns/100ps
module tape_mech_model (
   input wire logic pclk,
   output mode_sense_pkg::tape_t tape,
   output mode_sense_pkg::evt_t evt
);
   import mode_sense_pkg::*;
   initial
   begin
      tape = '0;
      evt = '0;
   end
   task load(input logic wp, input logic blank, input logic [7:0] rc, input logic [2:0] si, input logic [23:0] cap);
      begin
         @(posedge pclk);
         tape.loaded <= 1'b1;
         tape.wp <= wp;
         tape.blank <= blank;
         tape.rec_code <= rc;
         tape.size_idx <= si;
         tape.cap_kb <= cap;
         tape.load_done <= 1'b1;
         @(posedge pclk);
         tape.load_done <= 1'b0;
      end
   endtask
   // loaded and wp drop to zero; rec_code and cap_kb show the inverse of their last value
   task unload;
      begin
         @(posedge pclk);
         tape.loaded <= 1'b0;
         tape.wp <= 1'b0;
         tape.rec_code <= ~tape.rec_code;
         tape.cap_kb <= ~tape.cap_kb;
      end
   endtask
   // corrected size found near logical end
   task resize(input logic eur, input logic [2:0] idx);
      begin
         @(posedge pclk);
         tape.resize_valid <= 1'b1;
         tape.resize_eur <= eur;
         tape.resize_idx <= idx;
         @(posedge pclk);
         tape.resize_valid <= 1'b0;
      end
   endtask
   task pulse(input int idx);
      begin
         @(posedge pclk);
         evt[idx] <= 1'b1;
         @(posedge pclk);
         evt <= '0;
      end
   endtask
endmodule // tape_mech_model

//--- rtl/mode_sense_header.sv
// mode sense header and block descriptor builder with buffered-write control
// assumes APB master on pclk; tape status and events are pclk-synchronous, unload button is a raw pin
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module mode_sense_header #(
   parameter int WD_UNIT_CYCLES = mode_sense_pkg::WD_UNIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mode_sense_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire mode_sense_pkg::tape_t tape,
   input wire mode_sense_pkg::evt_t evt,
   input wire logic unload_btn,
   output logic flush_req,
   output logic cmd_status
);
   import mode_sense_pkg::*;

   logic pready_q, pslverr_q, flush_q, status_q;
   logic [31:0] prdata_q, rd_data;
   logic hit;
   logic dbd_q, ct_q, eur_q, xfer_q;
   logic [23:0] blk_len_q, blk_max_q, count_q;
   logic [15:0] wdelay_q, units_q;
   logic [31:0] tick_q;
   logic [7:0] page_len_q, medium_q;
   logic [7:0] write_fmt_q, rec_code_q;
   logic report_read_q, appended_q, written_q, blkerr_q, wp_q;
   logic btn_s1_q, btn_s2_q, btn_d_q;
   buf_state_t bs_q, bs_d;
   logic acc, wr_en, rd_cap;
   logic [7:0] hdr_len, hdr_mode, desc_len, density;
   logic btn_edge, ext_flush, timeout, flush_now;

   assign acc = psel && penable;
   assign rd_cap = ce && acc && !pready_q;
   assign wr_en = ce && acc && pwrite && pready_q;

   // one wait state, then pready
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else if (ce)
      begin
         pready_q <= acc && !pready_q;
         pslverr_q <= rd_cap && !hit;
         if (rd_cap)
         begin
            prdata_q <= pwrite ? 32'h00000000 : rd_data;
         end
      end
   end

   assign desc_len = dbd_q ? DESC_LEN_NONE : DESC_LEN_ONE;
   assign hdr_len = 8'(HDR_BASE_LEN + desc_len + page_len_q);
   assign hdr_mode = {wp_q, (xfer_q ? XFER_BUF : XFER_UNBUF), SPEED_FIXED};
   assign density = report_read_q ? rec_code_q : write_fmt_q;

   always_comb
   begin
      hit = 1'b1;
      rd_data = 32'h00000000;
      if (paddr == OFF_MODE)
      begin
         rd_data[MODE_DBD_BIT] = dbd_q;
         rd_data[MODE_CT_BIT] = ct_q;
         rd_data[MODE_EUR_BIT] = eur_q;
         rd_data[MODE_XFER_BIT] = xfer_q;
      end
      else if (paddr == OFF_DENSITY)
         rd_data[7:0] = write_fmt_q;
      else if (paddr == OFF_BLKLEN)
         rd_data[23:0] = blk_len_q;
      else if (paddr == OFF_BLKMAX)
         rd_data[23:0] = blk_max_q;
      else if (paddr == OFF_WDELAY)
         rd_data[15:0] = wdelay_q;
      else if (paddr == OFF_PAGELEN)
         rd_data[7:0] = page_len_q;
      else if (paddr == OFF_HEADER)
         rd_data = {hdr_len, medium_q, hdr_mode, desc_len};
      else if (paddr == OFF_DESC_HI)
         rd_data = {density, count_q};
      else if (paddr == OFF_DESC_LO)
         rd_data = RESV_BYTE | {8'h00, blk_len_q};
      else if (paddr == OFF_STATUS)
         rd_data[6:0] = {appended_q, report_read_q, bs_q != BS_EMPTY, tape.wp, blkerr_q, tape.loaded, written_q};
      else
         hit = 1'b0;
   end

   // mode bits, page length, write delay
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dbd_q <= 1'b0;
         ct_q <= 1'b0;
         eur_q <= 1'b0;
         xfer_q <= XFER_RESET;
         page_len_q <= PAGELEN_RESET;
         wdelay_q <= WDELAY_RESET;
         wp_q <= 1'b0;
      end
      else if (ce)
      begin
         wp_q <= tape.wp;
         if (wr_en && paddr == OFF_MODE)
         begin
            dbd_q <= pwdata[MODE_DBD_BIT];
            ct_q <= pwdata[MODE_CT_BIT];
            eur_q <= pwdata[MODE_EUR_BIT];
            xfer_q <= pwdata[MODE_XFER_BIT];
         end
         if (wr_en && paddr == OFF_PAGELEN)
            page_len_q <= pwdata[7:0];
         if (wr_en && paddr == OFF_WDELAY)
            wdelay_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blk_len_q <= BLKLEN_RESET;
         blk_max_q <= BLKMAX_RESET;
         blkerr_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_en && paddr == OFF_BLKMAX)
            blk_max_q <= pwdata[23:0];
         if (wr_en && paddr == OFF_BLKLEN && pwdata[23:0] <= blk_max_q)
            blk_len_q <= pwdata[23:0];
         if (wr_en && paddr == OFF_BLKLEN && pwdata[23:0] > blk_max_q)
            blkerr_q <= 1'b1;
         else if (wr_en && paddr == OFF_STATUS && pwdata[STAT_BLKERR_BIT])
            blkerr_q <= 1'b0;
      end
   end

   // medium code from load and resize
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         medium_q <= MED_NONE;
      else if (ce)
      begin
         if (!tape.loaded)
            medium_q <= MED_NONE;
         else if (tape.resize_valid)
            medium_q <= med_code(tape.resize_eur, tape.resize_idx);
         else if (tape.load_done)
            medium_q <= med_code(eur_q, tape.size_idx);
      end
   end

   function automatic logic [7:0] med_code(input logic eur, input logic [2:0] idx);
      logic [7:0] r;
      r = MED_NONE;
      if (eur && idx < EUR_SIZES)
         r = 8'(MED_EUR_BASE + idx);
      else if (!eur && idx < DOM_SIZES)
         r = 8'(MED_DOM_BASE + idx);
      return r;
   endfunction

   function automatic logic is_hi(input logic [7:0] c);
      return c == DENS_HI_A || c == DENS_HI_B;
   endfunction

   // density tracking
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         write_fmt_q <= DENS_RESET;
         rec_code_q <= DENS_RESET;
         report_read_q <= 1'b0;
         appended_q <= 1'b0;
         written_q <= 1'b0;
      end
      else if (ce)
      begin
         if (!tape.loaded)
         begin
            if (wr_en && paddr == OFF_DENSITY && pwdata[7:0] != DENS_KEEP)
               write_fmt_q <= pwdata[7:0];
            appended_q <= 1'b0;
            written_q <= 1'b0;
            report_read_q <= 1'b0;
         end
         else if (tape.load_done)
         begin
            appended_q <= 1'b0;
            written_q <= !tape.blank;
            report_read_q <= 1'b1;
            // blank tape reads as high density
            if (tape.blank)
               rec_code_q <= is_hi(write_fmt_q) ? write_fmt_q : DENS_HI_B;
            else
               rec_code_q <= tape.rec_code;
         end
         else if (evt.append && written_q)
         begin
            write_fmt_q <= rec_code_q;
            appended_q <= 1'b1;
            report_read_q <= 1'b0;
         end
         else if (wr_en && paddr == OFF_DENSITY)
         begin
            report_read_q <= 1'b0;
            if (pwdata[7:0] != DENS_KEEP && !appended_q)
               write_fmt_q <= pwdata[7:0];
         end
         else if (evt.write)
            report_read_q <= 1'b0;
         else if (evt.read)
            report_read_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_q <= 24'h000000;
      else if (ce)
      begin
         if (written_q ? is_hi(rec_code_q) : is_hi(density))
            count_q <= {tape.cap_kb[22:0], 1'b0};
         else
            count_q <= tape.cap_kb;
      end
   end

   // unload button synchroniser and edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         btn_s1_q <= 1'b0;
         btn_s2_q <= 1'b0;
         btn_d_q <= 1'b0;
      end
      else if (ce)
      begin
         btn_s1_q <= unload_btn;
         btn_s2_q <= btn_s1_q;
         btn_d_q <= btn_s2_q;
      end
   end
   assign btn_edge = btn_s2_q && !btn_d_q;

   assign ext_flush = evt.motion_thr || evt.rewind || evt.wfm_nonimm || evt.space || evt.erase
      || evt.load_unload || evt.locate_rev || btn_edge;
   assign timeout = wdelay_q != 16'h0000 && units_q >= wdelay_q;
   assign flush_now = ext_flush || timeout;

   // write delay timer, restarted by new data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_q <= 32'h00000000;
         units_q <= 16'h0000;
      end
      else if (ce)
      begin
         if (bs_q != BS_HOLD || evt.blk_in)
         begin
            tick_q <= 32'h00000000;
            units_q <= 16'h0000;
         end
         else if (tick_q >= 32'(WD_UNIT_CYCLES - 1))
         begin
            tick_q <= 32'h00000000;
            if (units_q != 16'hFFFF)
               units_q <= 16'(units_q + 16'h0001);
         end
         else
            tick_q <= 32'(tick_q + 32'h00000001);
      end
   end

   always_comb
   begin
      bs_d = bs_q;
      case (bs_q)
         BS_EMPTY:
            if (evt.blk_in)
               bs_d = xfer_q ? BS_HOLD : BS_FLUSH;
         BS_HOLD:
            if (!xfer_q || flush_now)
               bs_d = BS_FLUSH;
         BS_FLUSH:
            bs_d = evt.blk_in ? (xfer_q ? BS_HOLD : BS_FLUSH) : BS_EMPTY;
         default:
            bs_d = BS_EMPTY;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bs_q <= BS_EMPTY;
         flush_q <= 1'b0;
      end
      else if (ce)
      begin
         bs_q <= bs_d;
         flush_q <= bs_d == BS_FLUSH;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_q <= 1'b0;
      else if (ce)
         status_q <= xfer_q ? evt.last_blk : evt.on_tape;
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign flush_req = flush_q;
   assign cmd_status = status_q;

   chk_hdr_len: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_len == 8'(8'h03 + (dbd_q ? 8'h00 : 8'h08) + page_len_q))
      else $error("header length byte wrong");
   chk_desc_len: assert property (@(posedge pclk) disable iff (!presetn)
      (desc_len == 8'h00) == dbd_q && (desc_len == 8'h00 || desc_len == 8'h08))
      else $error("descriptor length wrong");
   chk_mode_byte: assert property (@(posedge pclk) disable iff (!presetn)
      hdr_mode[3:0] == 4'h0 && hdr_mode[6:5] == 2'b00 && hdr_mode[4] == xfer_q)
      else $error("mode byte malformed");
   chk_wp_follow: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> hdr_mode[7] == $past(tape.wp))
      else $error("write protect bit stale");
   chk_dens_keep: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == OFF_DENSITY && pwdata[7:0] == 8'h7F |=> $stable(write_fmt_q))
      else $error("7Fh changed writing format");
   chk_blk_limit: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == OFF_BLKLEN && pwdata[23:0] > blk_max_q |=> $stable(blk_len_q) && blkerr_q)
      else $error("oversize block length taken");
   chk_zero_delay: assert property (@(posedge pclk) disable iff (!presetn)
      ce && bs_q == BS_HOLD && xfer_q && !ext_flush && wdelay_q == 16'h0000 |=> !flush_q)
      else $error("flush on zero delay");
   chk_buf_flush: assert property (@(posedge pclk) disable iff (!presetn)
      ce && bs_q == BS_HOLD && ext_flush |=> flush_q ##1 !flush_q || evt.blk_in)
      else $error("flush event missed");
   chk_buf_status: assert property (@(posedge pclk) disable iff (!presetn)
      ce && xfer_q && evt.last_blk |=> cmd_status)
      else $error("buffered status late");
   chk_unbuf_status: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !xfer_q && !evt.on_tape |=> !cmd_status)
      else $error("unbuffered status early");
endmodule // mode_sense_header

//--- rtl/mode_sense_pkg.sv
// package: register map, field codes and carriers for the mode sense header block
// assumes one 40 MHz clock, an APB register port and same-clock tape status and events
//
// Overview of operation
// - header is four bytes: length, medium code, mode byte, descriptor length
// - length byte is three plus the count of selected parameter bytes
// - medium code 00h none, C1h..C4h European, 81h..85h domestic
// - medium code updates when resizing near logical end shows a wrong size
// - bit 7 of header byte 2 is the write protect state
// - transfer mode field is 000 unbuffered, 001 buffered, 001 after power-on
// - buffered data held until threshold, unload button or listed command flushes
// - write delay expiry flushes; zero delay never flushes on timeout
// - buffered status when last block buffered, unbuffered after physical write
// - speed field always reads zero
// - descriptor length is 00h or 08h, never more than one descriptor
// - descriptor: density, 24-bit count, reserved byte, 24-bit length, msb first
// - density shows writing format after power-on, mode select, write; else recorded
// - writing format comes from last mode select density other than 7Fh
// - blank tape load reports a high-density code
// - appending adopts the recorded format until the tape is removed
// - codes 00h and 15h mean high density, 14h the older format
// - block count is capacity in 1K blocks, doubled for high density
// - written tape count follows the recorded format, not the host setting
// - block length zero means variable, 400h after power-on
// - block length may not exceed the block limit; checked only when block length is written, not when the limit is lowered
// - descriptor included only when descriptor disable flag is zero
package mode_sense_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_DENSITY = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_BLKLEN = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_BLKMAX = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_WDELAY = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_PAGELEN = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_HEADER = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_DESC_HI = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_DESC_LO = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
   // mode register fields
   localparam int MODE_DBD_BIT = 0;
   localparam int MODE_CT_BIT = 1;
   localparam int MODE_EUR_BIT = 2;
   localparam int MODE_XFER_BIT = 4;
   localparam int STAT_BLKERR_BIT = 2;
   localparam logic [2:0] XFER_UNBUF = 3'h0;
   localparam logic [2:0] XFER_BUF = 3'h1;
   localparam logic XFER_RESET = 1'b1;
   localparam logic [7:0] HDR_BASE_LEN = 8'h03;
   localparam logic [7:0] DESC_LEN_NONE = 8'h00;
   localparam logic [7:0] DESC_LEN_ONE = 8'h08;
   localparam logic [3:0] SPEED_FIXED = 4'h0;
   localparam logic [7:0] MED_NONE = 8'h00;
   localparam logic [7:0] MED_EUR_BASE = 8'hC1;
   localparam logic [7:0] MED_DOM_BASE = 8'h81;
   localparam logic [2:0] EUR_SIZES = 3'h4;
   localparam logic [2:0] DOM_SIZES = 3'h5;
   localparam logic [7:0] DENS_HI_A = 8'h00;
   localparam logic [7:0] DENS_HI_B = 8'h15;
   localparam logic [7:0] DENS_LOW = 8'h14;
   localparam logic [7:0] DENS_KEEP = 8'h7F;
   localparam logic [7:0] DENS_RESET = 8'h00;
   localparam logic [23:0] BLKLEN_RESET = 24'h000400;
   localparam logic [23:0] BLKMAX_RESET = 24'h03C000;
   localparam logic [15:0] WDELAY_RESET = 16'h0000;
   localparam logic [7:0] PAGELEN_RESET = 8'h00;
   localparam logic [31:0] RESV_BYTE = 32'h00000000;
   // write delay unit and its cycle count
   localparam int CLK_PERIOD_NS = 25;
   localparam int WD_UNIT_NS = 100_000_000;
   localparam int WD_UNIT_CYC = WD_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      BS_EMPTY = 2'b00,
      BS_HOLD = 2'b01,
      BS_FLUSH = 2'b11
   } buf_state_t;

   typedef struct packed {
      logic loaded;
      logic wp;
      logic blank;
      logic [7:0] rec_code;
      logic [2:0] size_idx;
      logic [23:0] cap_kb;
      logic load_done;
      logic resize_valid;
      logic resize_eur;
      logic [2:0] resize_idx;
   } tape_t;

   typedef struct packed {
      logic motion_thr;
      logic rewind;
      logic wfm_nonimm;
      logic space;
      logic erase;
      logic load_unload;
      logic locate_rev;
      logic read;
      logic write;
      logic append;
      logic blk_in;
      logic last_blk;
      logic on_tape;
   } evt_t;
endpackage
